// ===== core/sfio_debounce.sv
// Synchroniser and stability filter for one safety input
`default_nettype none
module sfio_debounce #(
	parameter int CYCLES = sfio_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Raw and filtered level
	input wire logic raw_in,
	output logic clean_out,
	output logic settled_out
);
	localparam int CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

	logic sync_first;
	logic sync_second;
	logic sync_prev;
	logic [CNT_W-1:0] stable_count;
	wire logic changed = sync_second != sync_prev;
	wire logic done = stable_count == CNT_LAST;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			sync_first <= sfio_pkg::PIN_OPEN;
			sync_second <= sfio_pkg::PIN_OPEN;
			sync_prev <= sfio_pkg::PIN_OPEN;
		end
		else
		begin
			sync_first <= raw_in;
			sync_second <= sync_first;
			sync_prev <= sync_second;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			stable_count <= '0;
			clean_out <= sfio_pkg::PIN_OPEN;
			settled_out <= 1'h0;
		end
		else if (changed)
			stable_count <= '0;
		else if (done)
		begin
			clean_out <= sync_prev;
			settled_out <= 1'h1;
		end
		else
			stable_count <= stable_count + CNT_W'(1);
	end
endmodule
`default_nettype wire

// ===== core/sfio_mapper.sv
// Safety I/O device mapper: wired and network commands to status pins
// Contract
// (RL1) Wired input goes to selected command device
// (RL2) Network commands accepted beside the wired input
// (RL3) Safe-stop-1 command activates safe-stop-1
// (RL4) Open safe-stop-2 input activates stop and standstill
// (RL5) Open speed input activates limited speed 1
// (RL6) Open positive input permits increasing motion only
// (RL7) Open negative input permits decreasing motion only
// (RL8) Open increment input activates limited increment
// (RL9) Open torque input activates torque limit 1
// (RL10) Output pin shows selected status device
// (RL11) Wired output kept while network reports status
// (RL12) Speed monitor closed at or below monitor speed
// (RL13) Brake control signal on brake output
// (RL14) Torque-off status open while torque off active
// (RL15) Operating-stop status open during standstill monitoring; code opens it only while safe-stop-2 is also active
// (RL16) Stop-one and stop-two statuses open while active
// (RL17) Four limited-speed statuses open while active
// (RL18) Direction statuses open while direction monitoring active
// (RL19) Increment status open while limited increment active
// (RL20) Four limited-torque statuses open while active
// (RL21) Inputs synchronised, debounced, broken wire means active
// (RL22) Statuses held open until state known
`default_nettype none
module sfio_mapper #(
	parameter int DEBOUNCE_CYCLES = sfio_pkg::DEBOUNCE_CYCLES,
	parameter int SPEED_W = sfio_pkg::SPEED_W,
	parameter int TIME_W = sfio_pkg::TIME_W,
	parameter int TORQUE_W = sfio_pkg::TORQUE_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Wired safety input pin, 1 closed, 0 open
	input wire logic safety_in_pin,
	// Device selection settings
	input wire logic [sfio_pkg::SEL_W-1:0] input_device_select_setting,
	input wire logic [sfio_pkg::SEL_W-1:0] output_device_select_setting,
	// Network command path
	input wire logic net_enable,
	input wire sfio_pkg::sfio_cmd_t net_command_in,
	// Sub-function settings
	input wire logic [TIME_W-1:0] speed_limit_decel_monitor_time_1,
	input wire logic [SPEED_W-1:0] speed_limit_value_1,
	input wire logic [TORQUE_W-1:0] torque_upper_limit_1,
	input wire logic [TORQUE_W-1:0] torque_lower_limit_1,
	// Speed monitor inputs
	input wire logic [SPEED_W-1:0] motor_speed,
	input wire logic [SPEED_W-1:0] monitor_speed,
	// States reported by the sub-function cores
	input wire sfio_pkg::sfio_core_t core_state_in,
	// Activation requests to the sub-function cores
	output sfio_pkg::sfio_cmd_t active_out,
	output logic [TIME_W-1:0] speed_decel_time_out,
	output logic [SPEED_W-1:0] speed_limit_out,
	output logic [TORQUE_W-1:0] torque_upper_out,
	output logic [TORQUE_W-1:0] torque_lower_out,
	// Wired status output pin and network status image
	output logic safety_out_pin,
	output sfio_pkg::sfio_status_t net_status_out,
	// Individual status devices
	output logic speed_monitor_status_out,
	output logic brake_control_out,
	output logic torque_off_status_out,
	output logic operating_stop_status_out,
	output logic safe_stop_one_status_out,
	output logic safe_stop_two_status_out,
	output logic limited_speed_status_out_1,
	output logic limited_speed_status_out_2,
	output logic limited_speed_status_out_3,
	output logic limited_speed_status_out_4,
	output logic positive_direction_status_out,
	output logic negative_direction_status_out,
	output logic limited_increment_status_out,
	output logic limited_torque_status_out_1,
	output logic limited_torque_status_out_2,
	output logic limited_torque_status_out_3,
	output logic limited_torque_status_out_4
);
	// Wired command is active when its device is selected and pin open
	function automatic logic wired_active(
		input logic [sfio_pkg::SEL_W-1:0] sel,
		input logic [sfio_pkg::SEL_W-1:0] code,
		input logic level
	);
		wired_active = (sel == code) && (level == sfio_pkg::PIN_OPEN);
	endfunction

	// Status level: open while active
	function automatic logic status_level(input logic active);
		status_level = active ? sfio_pkg::PIN_OPEN : sfio_pkg::PIN_CLOSED;
	endfunction

	sfio_pkg::sfio_state_t state;
	sfio_pkg::sfio_state_t next_state;
	logic pin_level;
	logic pin_settled;

	// Filtered input, reset value open
	// (RL21) Filter and fail-safe level
	sfio_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_filter (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.raw_in(safety_in_pin),
		.clean_out(pin_level),
		.settled_out(pin_settled)
	);

	wire logic [sfio_pkg::SEL_W-1:0] in_sel = input_device_select_setting;
	wire logic [sfio_pkg::SEL_W-1:0] out_sel = output_device_select_setting;
	wire sfio_pkg::sfio_cmd_t net_cmd =
		net_enable ? net_command_in : '0;

	// (RL1) Wired input routing
	wire sfio_pkg::sfio_cmd_t wired_cmd = '{
		torque_off: wired_active(in_sel, sfio_pkg::IN_SEL_STO, pin_level),
		safe_stop_one: wired_active(in_sel, sfio_pkg::IN_SEL_SS1, pin_level),
		safe_stop_two: wired_active(in_sel, sfio_pkg::IN_SEL_SS2, pin_level),
		limited_speed_one:
			wired_active(in_sel, sfio_pkg::IN_SEL_SLS1, pin_level),
		positive_direction:
			wired_active(in_sel, sfio_pkg::IN_SEL_SDIP, pin_level),
		negative_direction:
			wired_active(in_sel, sfio_pkg::IN_SEL_SDIN, pin_level),
		limited_increment:
			wired_active(in_sel, sfio_pkg::IN_SEL_SLI, pin_level),
		limited_torque_one:
			wired_active(in_sel, sfio_pkg::IN_SEL_SLT1, pin_level)
	};

	// (RL2) Network merged with wired
	wire sfio_pkg::sfio_cmd_t merged_cmd = wired_cmd | net_cmd;

	// (RL3) Safe-stop-1 activation
	wire logic ss1_act = merged_cmd.safe_stop_one;
	// (RL4) Safe-stop-2 with operating stop
	wire logic ss2_act = merged_cmd.safe_stop_two;
	// (RL5) Limited speed 1 activation
	wire logic sls1_act = merged_cmd.limited_speed_one;
	// (RL6) Positive direction only
	wire logic sdip_act = merged_cmd.positive_direction;
	// (RL7) Negative direction only
	wire logic sdin_act = merged_cmd.negative_direction;
	// (RL8) Limited increment activation
	wire logic sli_act = merged_cmd.limited_increment;
	// (RL9) Torque limit 1 activation
	wire logic slt1_act = merged_cmd.limited_torque_one;

	wire logic sto_act = merged_cmd.torque_off;
	wire logic sos_act = ss2_act && core_state_in.standstill_monitor;
	wire logic [3:0] sls_act = {core_state_in.limited_speed_other, sls1_act};
	wire logic [3:0] slt_act = {core_state_in.limited_torque_other, slt1_act};

	// (RL12) Speed at or below monitor speed
	wire logic speed_ok = core_state_in.speed_monitor_running &&
		(motor_speed <= monitor_speed);

	wire sfio_pkg::sfio_status_t live_status = '{
		speed_monitor: speed_ok ? sfio_pkg::PIN_CLOSED : sfio_pkg::PIN_OPEN,
		// (RL13) Brake control pass-through
		brake_control: core_state_in.brake_control,
		// (RL14) Torque-off status
		torque_off: status_level(sto_act),
		// (RL15) Standstill monitoring status
		operating_stop: status_level(sos_act),
		// (RL16) Stop-one and stop-two status
		safe_stop_one: status_level(ss1_act),
		safe_stop_two: status_level(ss2_act),
		// (RL17) Four limited-speed statuses
		limited_speed: ~sls_act,
		// (RL18) Direction statuses
		positive_direction: status_level(sdip_act),
		negative_direction: status_level(sdin_act),
		// (RL19) Limited increment status
		limited_increment: status_level(sli_act),
		// (RL20) Four limited-torque statuses
		limited_torque: ~slt_act
	};

	// (RL22) Open statuses until input settled
	wire logic known = state == sfio_pkg::SFIO_RUN;
	wire sfio_pkg::sfio_status_t next_status = known ? live_status : '0;
	wire logic [sfio_pkg::STATUS_W-1:0] status_bits = next_status;
	wire logic out_sel_valid = (out_sel != sfio_pkg::OUT_SEL_NONE) &&
		(out_sel <= sfio_pkg::SEL_W'(sfio_pkg::STATUS_W));
	wire logic [sfio_pkg::SEL_W-1:0] out_index = out_sel - sfio_pkg::SEL_W'(1);
	wire logic [sfio_pkg::STATUS_W-1:0] msb_first =
		{<<{status_bits}};
	// (RL10) Output device selection
	wire logic next_out_pin =
		out_sel_valid ? msb_first[out_index] : sfio_pkg::PIN_OPEN;

	always_comb
	begin
		case (state)
			sfio_pkg::SFIO_INIT:
				next_state = pin_settled ? sfio_pkg::SFIO_RUN : sfio_pkg::SFIO_INIT;
			sfio_pkg::SFIO_RUN:
				next_state = sfio_pkg::SFIO_RUN;
			default:
				next_state = sfio_pkg::SFIO_INIT;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			state <= sfio_pkg::SFIO_INIT;
		else
			state <= next_state;
	end

	// Activation requests and their settings
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			active_out <= '1;
			speed_decel_time_out <= '0;
			speed_limit_out <= '0;
			torque_upper_out <= '0;
			torque_lower_out <= '0;
		end
		else
		begin
			active_out <= merged_cmd;
			speed_decel_time_out <= speed_limit_decel_monitor_time_1;
			speed_limit_out <= speed_limit_value_1;
			torque_upper_out <= torque_upper_limit_1;
			torque_lower_out <= torque_lower_limit_1;
		end
	end

	// (RL11) Wired pin and network image together
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			safety_out_pin <= sfio_pkg::PIN_OPEN;
			net_status_out <= '0;
		end
		else
		begin
			safety_out_pin <= next_out_pin;
			net_status_out <= next_status;
		end
	end

	// Individual status devices
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			speed_monitor_status_out <= sfio_pkg::PIN_OPEN;
			brake_control_out <= sfio_pkg::PIN_OPEN;
			torque_off_status_out <= sfio_pkg::PIN_OPEN;
			operating_stop_status_out <= sfio_pkg::PIN_OPEN;
			safe_stop_one_status_out <= sfio_pkg::PIN_OPEN;
			safe_stop_two_status_out <= sfio_pkg::PIN_OPEN;
			limited_speed_status_out_1 <= sfio_pkg::PIN_OPEN;
			limited_speed_status_out_2 <= sfio_pkg::PIN_OPEN;
			limited_speed_status_out_3 <= sfio_pkg::PIN_OPEN;
			limited_speed_status_out_4 <= sfio_pkg::PIN_OPEN;
			positive_direction_status_out <= sfio_pkg::PIN_OPEN;
			negative_direction_status_out <= sfio_pkg::PIN_OPEN;
			limited_increment_status_out <= sfio_pkg::PIN_OPEN;
			limited_torque_status_out_1 <= sfio_pkg::PIN_OPEN;
			limited_torque_status_out_2 <= sfio_pkg::PIN_OPEN;
			limited_torque_status_out_3 <= sfio_pkg::PIN_OPEN;
			limited_torque_status_out_4 <= sfio_pkg::PIN_OPEN;
		end
		else
		begin
			speed_monitor_status_out <= next_status.speed_monitor;
			brake_control_out <= next_status.brake_control;
			torque_off_status_out <= next_status.torque_off;
			operating_stop_status_out <= next_status.operating_stop;
			safe_stop_one_status_out <= next_status.safe_stop_one;
			safe_stop_two_status_out <= next_status.safe_stop_two;
			limited_speed_status_out_1 <= next_status.limited_speed[0];
			limited_speed_status_out_2 <= next_status.limited_speed[1];
			limited_speed_status_out_3 <= next_status.limited_speed[2];
			limited_speed_status_out_4 <= next_status.limited_speed[3];
			positive_direction_status_out <= next_status.positive_direction;
			negative_direction_status_out <= next_status.negative_direction;
			limited_increment_status_out <= next_status.limited_increment;
			limited_torque_status_out_1 <= next_status.limited_torque[0];
			limited_torque_status_out_2 <= next_status.limited_torque[1];
			limited_torque_status_out_3 <= next_status.limited_torque[2];
			limited_torque_status_out_4 <= next_status.limited_torque[3];
		end
	end
endmodule
`default_nettype wire

// ===== core/sfio_pkg.sv
// Package: shared types and constants of the safety I/O mapper
`default_nettype none
package sfio_pkg;

	// Pin levels: closed contact reads 1, open (or broken wire) reads 0
	localparam logic PIN_CLOSED = 1'h1;
	localparam logic PIN_OPEN = 1'h0;

	// Clock and input filter timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int DEBOUNCE_TIME_NS = 100000;
	localparam int DEBOUNCE_CYCLES =
		(DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Setting widths
	localparam int SEL_W = 5;
	localparam int SPEED_W = 16;
	localparam int TIME_W = 16;
	localparam int TORQUE_W = 16;

	// Input device codes for the wired safety input
	localparam logic [SEL_W-1:0] IN_SEL_NONE = 5'h00;
	localparam logic [SEL_W-1:0] IN_SEL_STO = 5'h01;
	localparam logic [SEL_W-1:0] IN_SEL_SS1 = 5'h02;
	localparam logic [SEL_W-1:0] IN_SEL_SS2 = 5'h03;
	localparam logic [SEL_W-1:0] IN_SEL_SLS1 = 5'h04;
	localparam logic [SEL_W-1:0] IN_SEL_SDIP = 5'h05;
	localparam logic [SEL_W-1:0] IN_SEL_SDIN = 5'h06;
	localparam logic [SEL_W-1:0] IN_SEL_SLI = 5'h07;
	localparam logic [SEL_W-1:0] IN_SEL_SLT1 = 5'h08;

	// Output device codes are 17 minus the bit index in the status vector
	localparam logic [SEL_W-1:0] OUT_SEL_NONE = 5'h00;
	localparam int STATUS_W = 17;

	// Command set: 1 means the command asks for activation
	typedef struct packed {
		logic torque_off;
		logic safe_stop_one;
		logic safe_stop_two;
		logic limited_speed_one;
		logic positive_direction;
		logic negative_direction;
		logic limited_increment;
		logic limited_torque_one;
	} sfio_cmd_t;

	// Status set: pin levels, 1 closed, 0 open
	typedef struct packed {
		logic speed_monitor;
		logic brake_control;
		logic torque_off;
		logic operating_stop;
		logic safe_stop_one;
		logic safe_stop_two;
		logic [3:0] limited_speed;
		logic positive_direction;
		logic negative_direction;
		logic limited_increment;
		logic [3:0] limited_torque;
	} sfio_status_t;

	// Activation states reported by the sub-function cores
	typedef struct packed {
		logic [2:0] limited_speed_other;
		logic [2:0] limited_torque_other;
		logic standstill_monitor;
		logic speed_monitor_running;
		logic brake_control;
	} sfio_core_t;

	typedef enum logic [1:0] {
		SFIO_INIT = 2'h1,
		SFIO_RUN = 2'h2
	} sfio_state_t;

endpackage
`default_nettype wire

// ===== tb/sfio_asserts.sv
// Port checker of the safety I/O mapper
`default_nettype none
module sfio_asserts #(
	parameter int SPEED_W = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Inputs watched
	input wire logic net_enable,
	input wire sfio_pkg::sfio_cmd_t net_command_in,
	input wire sfio_pkg::sfio_core_t core_state_in,
	input wire logic [SPEED_W-1:0] motor_speed,
	input wire logic [SPEED_W-1:0] monitor_speed,
	input wire logic [SPEED_W-1:0] speed_limit_value_1,
	input wire logic [sfio_pkg::SEL_W-1:0] output_device_select_setting,
	// Outputs watched
	input wire sfio_pkg::sfio_cmd_t active_out,
	input wire logic [SPEED_W-1:0] speed_limit_out,
	input wire logic safety_out_pin,
	input wire sfio_pkg::sfio_status_t net_status_out,
	input wire logic speed_monitor_status_out,
	input wire logic brake_control_out,
	input wire logic torque_off_status_out,
	input wire logic safe_stop_one_status_out,
	input wire logic safe_stop_two_status_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	property p_reset;
		$rose(reset_n) |-> net_status_out == '0 && active_out == '1;
	endproperty
	a_reset: assert property (p_reset) else $error("open after reset");
	property p_net;
		net_enable && net_command_in.safe_stop_one |=>
			active_out.safe_stop_one && !safe_stop_one_status_out;
	endproperty
	a_net: assert property (p_net) else $error("net stop one");
	property p_sto;
		active_out.torque_off |-> !torque_off_status_out;
	endproperty
	a_sto: assert property (p_sto) else $error("torque off status");
	property p_stop2;
		active_out.safe_stop_two |-> !safe_stop_two_status_out;
	endproperty
	a_stop2: assert property (p_stop2) else $error("stop two status");
	property p_speed;
		speed_monitor_status_out |-> $past(core_state_in.speed_monitor_running
			&& motor_speed <= monitor_speed);
	endproperty
	a_speed: assert property (p_speed) else $error("speed monitor");
	property p_brake;
		brake_control_out |-> $past(core_state_in.brake_control);
	endproperty
	a_brake: assert property (p_brake) else $error("brake output");
	property p_image;
		net_status_out.torque_off == torque_off_status_out &&
			net_status_out.speed_monitor == speed_monitor_status_out;
	endproperty
	a_image: assert property (p_image) else $error("network image");
	property p_sel_none;
		$past(output_device_select_setting) == 5'h00 |-> !safety_out_pin;
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("pin open");
	property p_sel_bit;
		$stable(output_device_select_setting) && $stable(net_status_out) &&
			output_device_select_setting inside {[5'h01:5'h11]} |->
			safety_out_pin ==
			net_status_out[5'h11 - output_device_select_setting];
	endproperty
	a_sel_bit: assert property (p_sel_bit) else $error("pin select");
	property p_setting;
		$past(reset_n) |-> speed_limit_out == $past(speed_limit_value_1);
	endproperty
	a_setting: assert property (p_setting) else $error("speed limit");
endmodule
bind sfio_mapper sfio_asserts #(.SPEED_W(SPEED_W)) u_sfio_asserts (
	.core_clk, .reset_n, .net_enable, .net_command_in, .core_state_in,
	.motor_speed, .monitor_speed, .speed_limit_value_1,
	.output_device_select_setting, .active_out, .speed_limit_out,
	.safety_out_pin, .net_status_out, .speed_monitor_status_out,
	.brake_control_out, .torque_off_status_out, .safe_stop_one_status_out,
	.safe_stop_two_status_out);
`default_nettype wire

// ===== tb/sfio_mapper_tb.sv
// Self-checking bench of the safety I/O mapper
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module sfio_mapper_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DB = 4;
	logic core_clk, reset_n, want_active, wire_broken, net_enable, out_pin;
	logic [sfio_pkg::SEL_W-1:0] in_sel, out_sel;
	sfio_pkg::sfio_cmd_t net_cmd, act;
	sfio_pkg::sfio_core_t core;
	sfio_pkg::sfio_status_t img;
	logic [15:0] dtime, slim, tup, tlow, mspeed, mon, dt_o, sl_o, tu_o, tl_o;
	wire logic pin;
	wire logic [16:0] st;
	int n_errors, checked;
	sfio_partner u_sfio_partner (.core_clk(core_clk), .want_active(want_active),
		.wire_broken(wire_broken), .contact_out(pin));
	sfio_mapper #(.DEBOUNCE_CYCLES(DB)) u_sfio_mapper (.core_clk(core_clk),
		.reset_n(reset_n), .safety_in_pin(pin),
		.input_device_select_setting(in_sel),
		.output_device_select_setting(out_sel), .net_enable(net_enable),
		.net_command_in(net_cmd), .speed_limit_decel_monitor_time_1(dtime),
		.speed_limit_value_1(slim), .torque_upper_limit_1(tup),
		.torque_lower_limit_1(tlow), .motor_speed(mspeed),
		.monitor_speed(mon), .core_state_in(core), .active_out(act),
		.speed_decel_time_out(dt_o), .speed_limit_out(sl_o),
		.torque_upper_out(tu_o), .torque_lower_out(tl_o),
		.safety_out_pin(out_pin), .net_status_out(img),
		.speed_monitor_status_out(st[16]), .brake_control_out(st[15]),
		.torque_off_status_out(st[14]), .operating_stop_status_out(st[13]),
		.safe_stop_one_status_out(st[12]), .safe_stop_two_status_out(st[11]),
		.limited_speed_status_out_1(st[10]), .limited_speed_status_out_2(st[9]),
		.limited_speed_status_out_3(st[8]), .limited_speed_status_out_4(st[7]),
		.positive_direction_status_out(st[6]),
		.negative_direction_status_out(st[5]),
		.limited_increment_status_out(st[4]),
		.limited_torque_status_out_1(st[3]), .limited_torque_status_out_2(st[2]),
		.limited_torque_status_out_3(st[1]), .limited_torque_status_out_4(st[0]));
	initial
	begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	// Expected status pins for a merged command
	function automatic logic [16:0] ex(input sfio_pkg::sfio_cmd_t a);
		return {core.speed_monitor_running && mspeed <= mon, core.brake_control,
			!a.torque_off, !(a.safe_stop_two && core.standstill_monitor),
			!a.safe_stop_one, !a.safe_stop_two, !a.limited_speed_one,
			!core.limited_speed_other[0], !core.limited_speed_other[1],
			!core.limited_speed_other[2], !a.positive_direction,
			!a.negative_direction, !a.limited_increment, !a.limited_torque_one,
			!core.limited_torque_other[0], !core.limited_torque_other[1],
			!core.limited_torque_other[2]};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_run();
		int i;
		for (i = 0; i < DB + 20 && st[14] !== 1'h1; i++)
			wt(1);
		`CHK("idle st", ex(8'h00), st)
		`CHK("idle act", 8'h00, act)
	endtask
	task automatic t_wired();
		int k;
		for (k = 1; k <= 9; k++)
		begin
			@(posedge core_clk) in_sel <= k[4:0];
			want_active <= 1'h1;
			wt(DB + 8);
			`CHK("wired act", (k < 9) ? 8'h80 >> (k - 1) : 8'h00, act)
			`CHK("wired st", ex(8'h80 >> (k - 1)), st)
			@(posedge core_clk) want_active <= 1'h0;
			wt(DB + 8);
			`CHK("wired off", 8'h00, act)
		end
	endtask
	task automatic t_filter();
		@(posedge core_clk) in_sel <= 5'h03;
		want_active <= 1'h1;
		wt(1);
		@(posedge core_clk) want_active <= 1'h0;
		wt(DB + 8);
		`CHK("glitch", 8'h00, act)
		@(posedge core_clk) wire_broken <= 1'h1;
		wt(DB + 8);
		`CHK("broken", 8'h20, act)
		@(posedge core_clk) wire_broken <= 1'h0;
		wt(DB + 8);
	endtask
	task automatic t_net();
		int i;
		@(posedge core_clk) net_enable <= 1'h1;
		for (i = 0; i < 8; i++)
		begin
			@(posedge core_clk) net_cmd <= 8'h01 << i;
			wt(1);
			`CHK("net act", 8'h01 << i, act)
			`CHK("net st", ex(8'h01 << i), st)
		end
		@(posedge core_clk) net_enable <= 1'h0;
		net_cmd <= 8'hFF;
		wt(2);
		`CHK("net off", 8'h00, act)
	endtask
	task automatic t_core();
		@(posedge core_clk) core <= 9'h1FF;
		mspeed <= 16'h0100;
		mon <= 16'h0100;
		net_enable <= 1'h1;
		net_cmd <= 8'h20;
		out_sel <= 5'h02;
		wt(2);
		`CHK("core st", ex(net_cmd), st)
		`CHK("net image", 17'h1D0F1, img)
		`CHK("pin brake", 1'h1, out_pin)
		@(posedge core_clk) mspeed <= 16'h0101;
		out_sel <= 5'h00;
		wt(2);
		`CHK("over speed", 1'h0, st[16])
		`CHK("pin none", 1'h0, out_pin)
		@(posedge core_clk) out_sel <= 5'h11;
		wt(2);
		`CHK("pin last", 1'h1, out_pin)
		@(posedge core_clk) out_sel <= 5'h12;
		wt(2);
		`CHK("pin invalid", 1'h0, out_pin)
	endtask
	task automatic t_settings();
		@(posedge core_clk) dtime <= 16'h1234;
		slim <= 16'h2345;
		tup <= 16'h3456;
		tlow <= 16'h4567;
		wt(2);
		`CHK("settings", 64'h1234234534564567, {dt_o, sl_o, tu_o, tl_o})
	endtask
	task automatic t_rerun();
		@(posedge core_clk) reset_n <= 1'h0;
		wt(2);
		`CHK("reset st", 17'h00000, st)
		`CHK("reset act", 8'hFF, act)
		@(posedge core_clk) reset_n <= 1'h1;
		wt(1);
		`CHK("rerun st", 17'h00000, st)
	endtask
	initial
	begin
		n_errors = 0;
		checked = 0;
		{reset_n, want_active, wire_broken, net_enable} = 4'h0;
		{in_sel, out_sel, net_cmd, core} = '0;
		{dtime, slim, tup, tlow, mspeed, mon} = '0;
		wt(7);
		`CHK("in reset", 17'h00000, st)
		@(posedge core_clk) reset_n <= 1'h1;
		t_run();
		t_wired();
		t_filter();
		t_net();
		t_core();
		t_settings();
		t_rerun();
		tally_and_finish();
	end
	initial
	begin
		repeat (3000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ===== tb/sfio_partner.sv
// Model of the wired safety contact of the controller
`default_nettype none
module sfio_partner (
	// Clock
	input wire logic core_clk,
	// Requested contact state
	input wire logic want_active,
	input wire logic wire_broken,
	// Contact level
	output logic contact_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial contact_out = sfio_pkg::PIN_CLOSED;
	always @(posedge core_clk)
		contact_out <= (wire_broken || want_active) ? sfio_pkg::PIN_OPEN :
			sfio_pkg::PIN_CLOSED;
endmodule
`default_nettype wire
